/* nbm_uart.sv */
// Purpose: Nine-bit multiprocessor serial port with address recognition
// Assumes: Byte register port, timer overflows supplied as pulses
// Notes: Status bank select and rate doubler come in as plain inputs
`timescale 1ns/1ps
module nbm_uart
  import nbm_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  input wire logic RATE_DOUBLER_I,
  input wire logic STATUS_BANK_SEL_I,
  input wire logic TX_TICK_SOURCE_SEL_I,
  input wire logic RX_TICK_SOURCE_SEL_I,
  input wire logic TMR1_OVF_I,
  input wire logic TMR4_OVF_I,
  input wire logic RX_I,
  output logic RX_O,
  output logic RX_OE_O,
  output logic TX_O,
  output logic SERIAL_EVENT_O
);

  // Control and status bits
  logic sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q;
  logic fe_q, ovr_q, col_q;
  logic [7:0] addr_q; // Own address value
  logic [7:0] mask_q; // Own address mask
  logic [7:0] rbuf_q; // Receive latch
  logic unread_q; // Latch holds a byte software has not read

  // Transmit engine
  nbm_tx_t tx_st_q;
  logic [10:0] tx_sh_q; // Frame shifter, LSB leaves first
  logic [3:0] tx_os_q; // Oversample count
  logic [3:0] tx_bit_q; // Bit index

  // Receive engine
  nbm_rx_t rx_st_q;
  logic [9:0] rx_sh_q; // Sample shifter, fills from the top
  logic [3:0] rx_os_q;
  logic [3:0] rx_bit_q;
  logic rx_prev_q; // Previous line level for edge detect

  // Shared synchronous-mode clock divider
  logic [3:0] s_cnt_q;

  // Decode
  wire [1:0] mode = {sm0_q, sm1_q};
  wire nine = mode[1]; // Modes 2 and 3 carry a ninth bit
  wire async = (mode != MODE_SYNC);
  wire bank = STATUS_BANK_SEL_I;
  wire wr_ctl = SFR_WR_I && (SFR_ADDR_I == OFS_CONTROL);
  wire wr_buf = SFR_WR_I && (SFR_ADDR_I == OFS_DATA);
  wire wr_adr = SFR_WR_I && (SFR_ADDR_I == OFS_ADDR);
  wire wr_msk = SFR_WR_I && (SFR_ADDR_I == OFS_MASK);
  wire rd_buf = SFR_RD_I && (SFR_ADDR_I == OFS_DATA);
  wire tx_tick;
  wire rx_tick;

  // Control read view swaps on bank select
  wire [2:0] top3 = bank ? {fe_q, ovr_q, col_q}
                         : {sm0_q, sm1_q, sm2_q};
  wire [7:0] ctl_view = {top3, ren_q, tb8_q, rb8_q, ti_q, ri_q};
  wire [7:0] rdata_d = (SFR_ADDR_I == OFS_CONTROL) ? ctl_view :
                       (SFR_ADDR_I == OFS_DATA) ? rbuf_q :
                       (SFR_ADDR_I == OFS_ADDR) ? addr_q :
                       (SFR_ADDR_I == OFS_MASK) ? mask_q : 8'h00;

  // Synchronous-mode shift clock
  wire s_active = (tx_st_q == TX_SYNC) || (rx_st_q == RX_SYNC);
  wire s_tick = s_active && (s_cnt_q == SYNC_LAST);

  // Transmit start and collision
  wire tx_busy = (tx_st_q != TX_IDLE) || (rx_st_q == RX_SYNC);
  wire tx_start = wr_buf && !tx_busy;
  wire col_set = wr_buf && tx_busy;
  wire [3:0] tx_last = nine ? TX_LAST_9 : TX_LAST_8;
  wire tx_shift_a = (tx_st_q == TX_ASYNC) && tx_tick && (tx_os_q == OVS_LAST);
  wire tx_shift_s = (tx_st_q == TX_SYNC) && s_tick;
  // Transmit flag at stop-bit start, or after the eighth sync bit
  wire ti_set = (tx_shift_a && (tx_bit_q + 4'h1 == tx_last))
                || (tx_shift_s && (tx_bit_q == SYNC_BITS_LAST));
  wire tx_ninth = nine ? tb8_q : 1'b1;

  // Receive sampling
  wire [9:0] rx_sh_new = {RX_I, rx_sh_q[9:1]};
  wire rx_fall = rx_prev_q && !RX_I;
  wire rx_go = (rx_st_q == RX_IDLE) && ren_q && async && rx_fall;
  wire rx_sync_go = (rx_st_q == RX_IDLE) && ren_q && !async && !ri_q
                    && (tx_st_q == TX_IDLE) && !wr_buf;
  wire rx_mid = rx_tick && (rx_os_q == OVS_LAST);
  wire rx_start_ok = (rx_st_q == RX_START) && rx_tick && (rx_os_q == OVS_MID);
  wire [3:0] rx_last = nine ? LAST_BIT_9 : LAST_BIT_8;
  wire rx_end = (rx_st_q == RX_BITS) && rx_mid && (rx_bit_q == rx_last);
  wire sync_sample = (rx_st_q == RX_SYNC) && s_tick;
  wire rx_sync_end = sync_sample && (rx_bit_q == SYNC_BITS_LAST);

  // Frame fields once the stop bit is in
  wire [7:0] rx_byte = nine ? rx_sh_new[7:0] : rx_sh_new[8:1];
  wire rx_ninth = rx_sh_new[8];
  wire rx_stop = rx_sh_new[9];

  // Own address: only masked positions compared
  wire own_hit = ((rx_byte ^ addr_q) & mask_q) == 8'h00;
  // Broadcast: ones of address OR mask must be received as ones
  wire bcast_hit = ((~rx_byte) & (addr_q | mask_q)) == 8'h00;
  wire mp_ok = nine ? (rx_ninth && (own_hit || bcast_hit))
                    : rx_stop;
  wire accept_a = rx_end && !ri_q && (!sm2_q || mp_ok);
  wire ri_set = accept_a || rx_sync_end;
  // Eight-bit mode keeps the stop bit in the ninth receive bit
  wire rb8_new = nine ? rx_ninth : rx_stop;
  wire ovr_set = accept_a && unread_q;
  wire fe_set = rx_end && !rx_stop;

  // Error flags clear only by writing zero with the status bank selected
  wire clr_ok = wr_ctl && bank;
  wire fe_d = fe_set || (fe_q && !(clr_ok && !SFR_WDATA_I[BIT_MODE_HI]));
  wire ovr_d = ovr_set || (ovr_q && !(clr_ok && !SFR_WDATA_I[BIT_MODE_LO]));
  wire col_d = col_set
               || (col_q && !(clr_ok && !SFR_WDATA_I[BIT_MULTIPROC]));
  // Hardware set wins over a same-cycle software clear
  wire ti_d = ti_set || (wr_ctl ? SFR_WDATA_I[BIT_TI] : ti_q);
  wire ri_d = ri_set || (wr_ctl ? SFR_WDATA_I[BIT_RI] : ri_q);

  // Line outputs
  wire sclk = (s_cnt_q < SYNC_HALF) ? 1'b0 : 1'b1;
  wire tx_line_d = s_active ? sclk :
                   (tx_st_q == TX_ASYNC) ? tx_sh_q[0] : 1'b1;
  wire rxoe_d = (tx_st_q == TX_SYNC);

  // Baud tick generators, one per direction
  nbm_tick u_tx_tick (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .mode_i(mode),
    .smod_i(RATE_DOUBLER_I),
    .src_sel_i(TX_TICK_SOURCE_SEL_I),
    .t1_ovf_i(TMR1_OVF_I),
    .t4_ovf_i(TMR4_OVF_I),
    .tick_o(tx_tick)
  );

  nbm_tick u_rx_tick (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .mode_i(mode),
    .smod_i(RATE_DOUBLER_I),
    .src_sel_i(RX_TICK_SOURCE_SEL_I),
    .t1_ovf_i(TMR1_OVF_I),
    .t4_ovf_i(TMR4_OVF_I),
    .tick_o(rx_tick)
  );

  // Control register and address registers
  always_ff @(posedge MCLK_I or posedge RST_I)
    if (RST_I)
    begin
      {sm0_q, sm1_q, sm2_q, ren_q} <= RST_CONTROL[7:4];
      {tb8_q, rb8_q, ti_q, ri_q} <= RST_CONTROL[3:0];
      {fe_q, ovr_q, col_q} <= 3'h0;
      addr_q <= RST_BYTE;
      mask_q <= RST_BYTE;
    end
    else
    begin
      // Mode bits writable only with the mode bank selected
      if (wr_ctl && !bank)
      begin
        sm0_q <= SFR_WDATA_I[BIT_MODE_HI];
        sm1_q <= SFR_WDATA_I[BIT_MODE_LO];
        sm2_q <= SFR_WDATA_I[BIT_MULTIPROC];
      end
      if (wr_ctl)
      begin
        ren_q <= SFR_WDATA_I[BIT_REN];
        tb8_q <= SFR_WDATA_I[BIT_TB8];
      end
      // Received ninth bit beats a software write
      if (accept_a)
        rb8_q <= rb8_new;
      else if (wr_ctl)
        rb8_q <= SFR_WDATA_I[BIT_RB8];
      ti_q <= ti_d;
      ri_q <= ri_d;
      fe_q <= fe_d;
      ovr_q <= ovr_d;
      col_q <= col_d;
      if (wr_adr)
        addr_q <= SFR_WDATA_I;
      if (wr_msk)
        mask_q <= SFR_WDATA_I;
    end

  // Receive latch and unread tracking
  always_ff @(posedge MCLK_I or posedge RST_I)
    if (RST_I)
    begin
      rbuf_q <= RST_BYTE;
      unread_q <= 1'b0;
    end
    else if (ri_set)
    begin
      rbuf_q <= accept_a ? rx_byte : rx_sh_new[9:2];
      unread_q <= 1'b1;
    end
    else if (rd_buf)
      unread_q <= 1'b0;

  // Synchronous clock divider
  always_ff @(posedge MCLK_I or posedge RST_I)
    if (RST_I)
      s_cnt_q <= 4'h0;
    else if (!s_active || s_tick)
      s_cnt_q <= 4'h0;
    else
      s_cnt_q <= s_cnt_q + 4'h1;

  // Transmit engine
  always_ff @(posedge MCLK_I or posedge RST_I)
    if (RST_I)
    begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 11'h7FF;
      tx_os_q <= 4'h0;
      tx_bit_q <= 4'h0;
    end
    else
    begin
      case (tx_st_q)
        TX_IDLE:
          if (tx_start)
          begin
            // Stop, ninth, data, start; sync sends data only
            tx_sh_q <= async ? {1'b1, tx_ninth, SFR_WDATA_I, 1'b0}
                             : {3'h7, SFR_WDATA_I};
            tx_os_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_st_q <= async ? TX_ASYNC : TX_SYNC;
          end
        TX_ASYNC:
          if (tx_tick)
          begin
            tx_os_q <= tx_os_q + 4'h1;
            if (tx_os_q == OVS_LAST)
            begin
              tx_sh_q <= {1'b1, tx_sh_q[10:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == tx_last)
                tx_st_q <= TX_IDLE;
            end
          end
        TX_SYNC:
          if (s_tick)
          begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == SYNC_BITS_LAST)
              tx_st_q <= TX_IDLE;
          end
        default:
          tx_st_q <= TX_IDLE;
      endcase
    end

  // Receive engine
  always_ff @(posedge MCLK_I or posedge RST_I)
    if (RST_I)
    begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= 10'h000;
      rx_os_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_prev_q <= RX_I;
      // Clearing receive enable abandons a frame in flight
      if (!ren_q)
        rx_st_q <= RX_IDLE;
      else
        case (rx_st_q)
          RX_IDLE:
          begin
            rx_os_q <= 4'h0;
            rx_bit_q <= 4'h0;
            if (rx_go)
              rx_st_q <= RX_START;
            else if (rx_sync_go)
              rx_st_q <= RX_SYNC;
          end
          RX_START:
            if (rx_tick)
            begin
              rx_os_q <= rx_os_q + 4'h1;
              // Start bit checked at its middle, glitches rejected
              if (rx_os_q == OVS_MID)
              begin
                rx_os_q <= 4'h0;
                rx_st_q <= RX_I ? RX_IDLE : RX_BITS;
              end
            end
          RX_BITS:
            if (rx_tick)
            begin
              rx_os_q <= rx_os_q + 4'h1;
              if (rx_mid)
              begin
                rx_sh_q <= rx_sh_new;
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_end)
                  rx_st_q <= RX_IDLE;
              end
            end
          RX_SYNC:
            if (sync_sample)
            begin
              rx_sh_q <= rx_sh_new;
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_sync_end)
                rx_st_q <= RX_IDLE;
            end
          default:
            rx_st_q <= RX_IDLE;
        endcase
    end

  // Registered outputs
  always_ff @(posedge MCLK_I or posedge RST_I)
    if (RST_I)
    begin
      SFR_RDATA_O <= 8'h00;
      TX_O <= 1'b1;
      RX_O <= 1'b1;
      RX_OE_O <= 1'b0;
      SERIAL_EVENT_O <= 1'b0;
    end
    else
    begin
      if (SFR_RD_I)
        SFR_RDATA_O <= rdata_d;
      TX_O <= tx_line_d;
      RX_O <= tx_sh_q[0];
      RX_OE_O <= rxoe_d;
      SERIAL_EVENT_O <= ti_q || ri_q;
    end

endmodule : nbm_uart

/* nbm_pkg.sv */
// Purpose: Shared constants for the nine-bit multiprocessor serial port
// Assumes: Byte-wide special function register access
// Notes: All offsets, reset values and cycle counts live here
package nbm_pkg;

  // Register offsets on the special function register port
  localparam logic [7:0] OFS_CONTROL = 8'hF1;
  localparam logic [7:0] OFS_DATA = 8'hF2;
  localparam logic [7:0] OFS_ADDR = 8'hF3;
  localparam logic [7:0] OFS_MASK = 8'hAE;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Control register bit positions
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_MULTIPROC = 5;
  localparam int BIT_REN = 4;
  localparam int BIT_TB8 = 3;
  localparam int BIT_RB8 = 2;
  localparam int BIT_TI = 1;
  localparam int BIT_RI = 0;

  // Mode field encodings
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_8VAR = 2'h1;
  localparam logic [1:0] MODE_9FIX = 2'h2;
  localparam logic [1:0] MODE_9VAR = 2'h3;

  // Sixteen-times oversampling counts
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;

  // Fixed-rate tick: bit time 64 or 32 clocks, so 4 or 2 clocks a tick
  localparam int FIX_BIT_SLOW = 64;
  localparam int FIX_BIT_FAST = 32;
  localparam int OVS_FACTOR = 16;
  localparam logic [1:0] FIX_LAST_SLOW = 2'(FIX_BIT_SLOW / OVS_FACTOR - 1);
  localparam logic [1:0] FIX_LAST_FAST = 2'(FIX_BIT_FAST / OVS_FACTOR - 1);

  // Synchronous mode: bit time of 12 clocks, clock low for first half
  localparam logic [3:0] SYNC_LAST = 4'hB;
  localparam logic [3:0] SYNC_HALF = 4'h6;

  // Frame bit indices
  localparam logic [3:0] LAST_BIT_8 = 4'h8;
  localparam logic [3:0] LAST_BIT_9 = 4'h9;
  localparam logic [3:0] TX_LAST_8 = 4'h9;
  localparam logic [3:0] TX_LAST_9 = 4'hA;
  localparam logic [3:0] SYNC_BITS_LAST = 4'h7;

  // Engine states
  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} nbm_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_SYNC} nbm_rx_t;

endpackage : nbm_pkg

/* nbm_tick.sv */
// Purpose: Oversampling tick for one direction of the serial port
// Assumes: Timer overflow inputs are one-cycle pulses
// Notes: One tick is a sixteenth of a bit time
`timescale 1ns/1ps
module nbm_tick
  import nbm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic smod_i,
  input wire logic src_sel_i,
  input wire logic t1_ovf_i,
  input wire logic t4_ovf_i,
  output logic tick_o
);

  logic [1:0] fix_q; // Fixed-rate divider
  logic half_q; // Halves the auto-reload timer rate
  logic fix_tick; // Fixed-rate tick
  logic var_tick; // Timer-derived tick
  logic tick_d;

  // Fixed rate: system clock over 64, or over 32 when doubled
  assign fix_tick = smod_i ? (fix_q[0] == FIX_LAST_FAST[0])
                           : (fix_q == FIX_LAST_SLOW);
  // Second timer already runs at half rate; first timer halved w/o doubler
  assign var_tick = src_sel_i ? t4_ovf_i
                              : (t1_ovf_i & (smod_i | half_q));
  assign tick_d = (mode_i == MODE_9FIX) ? fix_tick :
                  (mode_i == MODE_SYNC) ? 1'b0 : var_tick;

  // Dividers and tick register
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      fix_q <= 2'h0;
      half_q <= 1'b0;
      tick_o <= 1'b0;
    end
    else
    begin
      fix_q <= fix_q + 2'h1;
      if (t1_ovf_i && !src_sel_i)
        half_q <= ~half_q;
      tick_o <= tick_d;
    end

endmodule : nbm_tick

/* nbm_assertions.sv */
// Purpose: Port assertions for the nine-bit serial port
// Assumes: Register port and line timing as handed over
// Notes: Bound into every instance of the top module
`timescale 1ns/1ps
module nbm_chk
  import nbm_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic STATUS_BANK_SEL_I,
  input wire logic RX_OE_O,
  input wire logic TX_O,
  input wire logic SERIAL_EVENT_O
);
  logic mapped; // Address hits a register
  logic ctl_rd; // Control register read
  assign mapped = SFR_ADDR_I inside {OFS_CONTROL, OFS_DATA, OFS_ADDR, OFS_MASK};
  assign ctl_rd = SFR_RD_I && SFR_ADDR_I == OFS_CONTROL;
  default clocking dc @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  // Write, idle, read of one place returns the written bits
  property p_back(logic [7:0] a, logic [7:0] m);
    SFR_WR_I && SFR_ADDR_I == a && !STATUS_BANK_SEL_I ##2
    SFR_RD_I && SFR_ADDR_I == a && !STATUS_BANK_SEL_I
    |=> (SFR_RDATA_O & m) == ($past(SFR_WDATA_I, 3) & m);
  endproperty
  a_rdata_holds: assert property (!$past(SFR_RD_I) |->
    $stable(SFR_RDATA_O)) else $error("read data moved without a read");
  a_unmapped_zero: assert property ($past(SFR_RD_I && !mapped) |->
    SFR_RDATA_O == 8'h00) else $error("unmapped read not zero");
  a_event_flags: assert property ($past(ctl_rd) |->
    SERIAL_EVENT_O == (SFR_RDATA_O[BIT_TI] | SFR_RDATA_O[BIT_RI]))
    else $error("event output disagrees with flags");
  a_low_width: assert property ($fell(TX_O) |-> !TX_O [*6])
    else $error("transmit low phase too short");
  a_oe_span: assert property ($rose(RX_OE_O) |-> RX_OE_O [*8])
    else $error("data drive dropped early");
  a_addr_back: assert property (p_back(OFS_ADDR, 8'hFF))
    else $error("own address readback wrong");
  a_mask_back: assert property (p_back(OFS_MASK, 8'hFF))
    else $error("address mask readback wrong");
  a_ctl_back: assert property (p_back(OFS_CONTROL, 8'hF8))
    else $error("control readback wrong");
  // Main scenarios reached
  c_event: cover property ($rose(SERIAL_EVENT_O));
  c_sync: cover property ($rose(RX_OE_O));
  c_hole: cover property ($past(SFR_RD_I && !mapped));
endmodule : nbm_chk

bind nbm_uart nbm_chk u_chk (.MCLK_I, .RST_I, .SFR_ADDR_I, .SFR_WR_I,
  .SFR_RD_I, .SFR_WDATA_I, .SFR_RDATA_O, .STATUS_BANK_SEL_I, .RX_OE_O,
  .TX_O, .SERIAL_EVENT_O);

/* nbm_remote.sv */
// Purpose: Remote serial port on the far end of the line
// Assumes: Bit time given in core clocks, line idles high
// Notes: Captures device frames, sends frames on request
`timescale 1ns/1ps
module nbm_remote (
  input wire logic clk_i,
  input wire logic [7:0] bit_clks_i,
  input wire logic line_i,
  output logic line_o
);
  logic [9:0] frame_q = 10'h000; // Last frame: stop, ninth, data
  int frames = 0; // Frames captured so far
  initial line_o = 1'b1;
  // Capture at mid bit: data LSB first, ninth, stop
  always
  begin
    @(negedge line_i);
    repeat (bit_clks_i / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      repeat (bit_clks_i) @(posedge clk_i);
      frame_q[i] = line_i;
    end
    frames++;
  end
  // Send start, data LSB first, ninth, stop, then one idle bit
  task automatic send(input logic [7:0] d, input logic b9, input logic stp);
    logic [11:0] f;
    f = {1'b1, stp, b9, d, 1'b0};
    for (int i = 0; i < 12; i++)
    begin
      line_o = f[i];
      repeat (bit_clks_i) @(posedge clk_i);
      #1;
    end
  endtask : send
endmodule : nbm_remote

/* tb_top.sv */
// Purpose: Self-checking bench for the nine-bit serial port
// Assumes: Remote port model on the line, timer ticks made here
// Notes: Register accesses take two cycles each
`timescale 1ns/1ps
module tb_top
  import nbm_pkg::*;
;
  logic clk = 1'b0; // Core clock
  logic rst = 1'b1; // Reset, held at start
  logic [7:0] addr = 8'h00; // Register address
  logic wr_s = 1'b0; // Write strobe
  logic rd_s = 1'b0; // Read strobe
  logic [7:0] wdata = 8'h00; // Write data
  logic dbl = 1'b0; // Rate doubler
  logic bank = 1'b0; // Status bank select
  logic txs = 1'b0; // Transmit ticks from timer four
  logic rxs = 1'b0; // Receive ticks from timer one
  logic t1 = 1'b0; // Timer one overflow, every other cycle
  logic t4 = 1'b1; // Timer four overflow, every cycle
  logic [7:0] bitc = 8'd32; // Bit time seen by the remote port
  logic [7:0] rdata; // Read data
  logic [7:0] sdat = 8'h00; // Sync data seen at rising shift clock
  logic rx_o, oe, tx, ev, line, rx_pin; // Line and event wires
  int fails = 0;
  int tests_run = 0;
  logic [7:0] regs [5] = '{OFS_CONTROL, OFS_DATA, OFS_ADDR, OFS_MASK, 8'h00};
  logic [7:0] txd [2] = '{8'hA5, 8'h3C}; // Transmit bytes
  // Accept flag, ninth bit, byte
  logic [9:0] rxt [5] = '{10'h305, 10'h015, 10'h106, 10'h3FF, 10'h13E};
  // Shared receive pin: device drives it only during sync transmit
  assign rx_pin = oe ? rx_o : line;
  always #5 clk = ~clk;
  always @(posedge clk) t1 <= #1 ~t1;
  // Sync transmit data, taken LSB first on each rising shift clock
  always @(posedge tx)
    if (oe)
      sdat <= {rx_o, sdat[7:1]};
  nbm_uart u_dut (
    .MCLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr), .SFR_WR_I(wr_s),
    .SFR_RD_I(rd_s), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata),
    .RATE_DOUBLER_I(dbl), .STATUS_BANK_SEL_I(bank),
    .TX_TICK_SOURCE_SEL_I(txs), .RX_TICK_SOURCE_SEL_I(rxs),
    .TMR1_OVF_I(t1), .TMR4_OVF_I(t4), .RX_I(rx_pin), .RX_O(rx_o),
    .RX_OE_O(oe), .TX_O(tx), .SERIAL_EVENT_O(ev)
  );
  nbm_remote u_rem (.clk_i(clk), .bit_clks_i(bitc), .line_i(tx),
    .line_o(line));
  // Compare and count
  task automatic chk(input string n, input logic [9:0] g, e);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Register write, strobe over one edge
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(posedge clk);
    #1 wr_s = 1'b0;
  endtask : wr
  // Register read, masked compare
  task automatic rc(input logic [7:0] a, m, e, input string n);
    @(posedge clk);
    #1 addr = a;
    rd_s = 1'b1;
    @(posedge clk);
    #1 rd_s = 1'b0;
    chk(n, {2'b00, rdata & m}, {2'b00, e});
  endtask : rc
  // Bounded wait for the event output or a frame count
  task automatic hold(input logic use_ev, input int n);
    int k;
    k = 0;
    while ((use_ev ? ev !== 1'b1 : u_rem.frames != n) && k < 2000)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000)
    begin
      fails++;
      test_done();
    end
    repeat (40) @(posedge clk);
    #1;
  endtask : hold
  // Counts and verdict
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    // Reset values and an unmapped hole
    foreach (regs[i]) rc(regs[i], 8'hFF, 8'h00, "reset");
    // Every mode code, ninth bit set; receiver off so mode 0 stays idle
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_CONTROL, {2'(m), 6'h08});
      rc(OFS_CONTROL, 8'hF8, {2'(m), 6'h08}, "mode");
    end
    bank = 1'b1;
    wr(OFS_CONTROL, 8'h00);
    bank = 1'b0;
    rc(OFS_CONTROL, 8'hFF, 8'hC0, "mode kept");
    // Mode 3 transmit on timer four, collision on first frame
    txs = 1'b1;
    bitc = 8'd16;
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_CONTROL, i ? 8'hC0 : 8'hC8);
      wr(OFS_DATA, txd[i]);
      if (i == 0)
        wr(OFS_DATA, 8'hFF);
      hold(1'b0, i + 1);
      chk("tx frame", u_rem.frame_q, {1'b1, i == 0, txd[i]});
    end
    rc(OFS_CONTROL, 8'h02, 8'h02, "tx done");
    bank = 1'b1;
    rc(OFS_CONTROL, 8'hE0, 8'h20, "collision");
    wr(OFS_CONTROL, 8'h00);
    rc(OFS_CONTROL, 8'hE3, 8'h00, "cleared");
    bank = 1'b0;
    // Mode 2 doubled, address filtering
    dbl = 1'b1;
    bitc = 8'd32;
    wr(OFS_ADDR, 8'h35);
    rc(OFS_ADDR, 8'hFF, 8'h35, "own address");
    wr(OFS_MASK, 8'h0F);
    rc(OFS_MASK, 8'hFF, 8'h0F, "mask");
    foreach (rxt[i])
    begin
      wr(OFS_CONTROL, 8'hB0);
      u_rem.send(rxt[i][7:0], rxt[i][8], 1'b1);
      rc(OFS_CONTROL, 8'h05, rxt[i][9] ? 8'h05 : 8'h00, "filter");
      if (rxt[i][9])
        rc(OFS_DATA, 8'hFF, rxt[i][7:0], "rx byte");
    end
    // Plain reception, overrun, then a low stop bit
    wr(OFS_CONTROL, 8'h90);
    u_rem.send(8'h3C, 1'b0, 1'b1);
    rc(OFS_CONTROL, 8'h05, 8'h01, "ninth bit");
    wr(OFS_CONTROL, 8'h90);
    u_rem.send(8'hC3, 1'b0, 1'b1);
    rc(OFS_DATA, 8'hFF, 8'hC3, "second byte");
    u_rem.send(8'h77, 1'b1, 1'b0);
    bank = 1'b1;
    rc(OFS_CONTROL, 8'hE1, 8'hC1, "errors");
    wr(OFS_CONTROL, 8'h00);
    bank = 1'b0;
    u_rem.send(8'h12, 1'b0, 1'b1);
    rc(OFS_CONTROL, 8'hFF, 8'h80, "receiver off");
    // Mode 1 on timer one with stop checking
    wr(OFS_CONTROL, 8'h70);
    u_rem.send(8'h5A, 1'b0, 1'b1);
    rc(OFS_CONTROL, 8'h05, 8'h00, "bad stop");
    u_rem.send(8'h5A, 1'b1, 1'b1);
    rc(OFS_CONTROL, 8'h05, 8'h05, "good stop");
    // Synchronous transmit of one byte
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_DATA, 8'h96);
    hold(1'b1, 0);
    rc(OFS_CONTROL, 8'h03, 8'h02, "sync done");
    chk("sync data", {2'b00, sdat}, 10'h096);
    // Synchronous reception of an idle line
    wr(OFS_CONTROL, 8'h10);
    rc(OFS_CONTROL, 8'h03, 8'h00, "sync rx busy");
    hold(1'b1, 0);
    rc(OFS_DATA, 8'hFF, 8'hFF, "sync rx");
    test_done();
  end
endmodule : tb_top
